// >>> logic/tpf_consts.vh
// constants for the transaction-aware counter filter block
`ifndef TPF_CONSTS_VH
`define TPF_CONSTS_VH

// apb register byte offsets
`define TPF_OFF_EVTSEL_LO0 8'h00
`define TPF_OFF_EVTSEL_HI0 8'h04
`define TPF_EVTSEL_STRIDE 8'h08
`define TPF_OFF_CNT0 8'h20
`define TPF_CNT_STRIDE 8'h04
`define TPF_OFF_INFO_LO 8'h30
`define TPF_OFF_INFO_HI 8'h34
`define TPF_OFF_TRIG_IP 8'h38
`define TPF_OFF_RESUME_IP 8'h3C
`define TPF_OFF_SAMP_STAT 8'h40

// event select low word fields
`define TPF_SEL_CODE_LSB 0
`define TPF_SEL_UMASK_LSB 8
`define TPF_SEL_PRECISE_BIT 17
`define TPF_SEL_ENABLE_BIT 22
// event select high word: bits 32 and 33 of the full select
`define TPF_SEL_INTX_BIT 0
`define TPF_SEL_INTXCP_BIT 1

// counter that alone may carry the checkpoint filter
`define TPF_CKPT_CNT_IDX 2
`define TPF_NUM_CNT 4

// abort events that support precise sampling
`define TPF_EVT_ELIDED_ABORT 8'hC8
`define TPF_EVT_RESTR_ABORT 8'hC9
`define TPF_UMASK_ABORT 8'h04

// abort information record bit positions
`define TPF_INFO_CYC_MSB 31
`define TPF_INFO_ELIDED_BIT 32
`define TPF_INFO_RESTR_BIT 33
`define TPF_INFO_INSTR_BIT 34
`define TPF_INFO_NONINSTR_BIT 35
`define TPF_INFO_RETRY_BIT 36
`define TPF_INFO_CONFLICT_BIT 37
`define TPF_INFO_CAPWR_BIT 38
`define TPF_INFO_CAPRD_BIT 39

// reset values
`define TPF_RST_WORD 32'h00000000
`define TPF_RST_INFO 64'h0000000000000000

`endif

// >>> logic/tpf_cnt.v
// one filtered performance counter with transactional checkpoint
`timescale 1ns/10ps
`default_nettype none
`include "tpf_consts.vh"

module tpf_cnt (
  input wire mclk,
  input wire srst,
  input wire evt_hit,
  input wire in_tx,
  input wire txn_checkpoint_filter,
  input wire txn_active,
  input wire txn_begin,
  input wire txn_abort,
  input wire wr_en,
  input wire [31:0] wr_data,
  output wire [31:0] cnt
);

  reg [31:0] cnt_ff;
  reg [31:0] ckpt_ff;
  reg [31:0] nxt_cnt;
  wire count_ok;

  // transaction-only filter drops events outside a region; clear bits count everything
  assign count_ok = evt_hit & (~in_tx | txn_active);

  // checkpoint taken at region entry, before any in-region increment lands
  always @(posedge mclk) begin
    if (srst) begin
      ckpt_ff <= `TPF_RST_WORD;
    end else if (txn_begin) begin
      ckpt_ff <= cnt_ff;
    end
  end

  // software write wins, then abort restore, then counting
  always @* begin
    nxt_cnt = cnt_ff;
    if (wr_en) begin
      nxt_cnt = wr_data;
    end else if (txn_abort & txn_checkpoint_filter) begin
      nxt_cnt = ckpt_ff;
    end else if (count_ok) begin
      nxt_cnt = cnt_ff + 32'h00000001;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      cnt_ff <= `TPF_RST_WORD;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign cnt = cnt_ff;

endmodule // tpf_cnt
`default_nettype wire

// >>> logic/tpf_top.v
// transaction-aware counter filter with precise-sample ordering and abort record
`timescale 1ns/10ps
`default_nettype none
`include "tpf_consts.vh"

module tpf_top (
  input wire mclk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire core_evt_vld,
  input wire [7:0] core_evt_code,
  input wire [7:0] core_evt_umask,
  input wire [31:0] core_evt_ip,
  input wire txn_active,
  input wire txn_begin,
  input wire txn_commit,
  input wire txn_abort,
  input wire txn_kind_restricted,
  input wire abort_instr,
  input wire abort_retry,
  input wire abort_conflict,
  input wire abort_cap_wr,
  input wire abort_cap_rd,
  input wire [31:0] elided_restart_ip,
  input wire [31:0] fallback_ip,
  output reg txn_abort_req,
  output reg samp_valid,
  output reg samp_partial,
  output reg [31:0] samp_trig_ip,
  output reg [31:0] samp_resume_ip,
  output reg [63:0] samp_abort_info,
  output reg resume_valid,
  output reg resume_to_fallback,
  output reg [31:0] resume_ip
);

  // transactional filter bits are honoured only when a mode is present
  parameter TXN_SUPPORTED = 1'b1;

  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_EMIT = 3'b100;

  // event select match, shared by generic and abort event paths
  function evt_match;
    input [31:0] sel;
    input [7:0] code;
    input [7:0] umask;
    begin
      evt_match = (sel[`TPF_SEL_CODE_LSB +: 8] == code) && (sel[`TPF_SEL_UMASK_LSB +: 8] == umask);
    end
  endfunction

  // abort information word from the abort-cycle causes
  function [63:0] build_info;
    input [31:0] cyc;
    input restricted;
    input instr;
    input retry;
    input conflict;
    input cap_wr;
    input cap_rd;
    begin
      build_info = `TPF_RST_INFO;
      build_info[`TPF_INFO_CYC_MSB:0] = cyc;
      build_info[`TPF_INFO_ELIDED_BIT] = ~restricted;
      build_info[`TPF_INFO_RESTR_BIT] = restricted;
      build_info[`TPF_INFO_INSTR_BIT] = instr;
      build_info[`TPF_INFO_NONINSTR_BIT] = ~instr;
      build_info[`TPF_INFO_RETRY_BIT] = retry;
      build_info[`TPF_INFO_CONFLICT_BIT] = conflict;
      build_info[`TPF_INFO_CAPWR_BIT] = cap_wr;
      build_info[`TPF_INFO_CAPRD_BIT] = cap_rd;
    end
  endfunction

  reg [31:0] sel_lo_ff [0:`TPF_NUM_CNT-1];
  reg [1:0] sel_hi_ff [0:`TPF_NUM_CNT-1];
  wire [31:0] cnt_val [0:`TPF_NUM_CNT-1];
  wire [`TPF_NUM_CNT-1:0] gen_hit;
  wire [`TPF_NUM_CNT-1:0] abt_hit;
  wire [`TPF_NUM_CNT-1:0] prec_gen;
  wire [`TPF_NUM_CNT-1:0] prec_abt;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [31:0] txn_cyc_ff;
  reg [31:0] last_cyc_ff;
  reg samp_pend_ff;
  wire elided_abort_event;
  wire restricted_abort_event;
  wire acc;
  wire setup;
  wire wr_take;
  wire [31:0] cyc_now;
  wire [63:0] abort_info_now;
  wire [31:0] abort_resume_now;
  reg [31:0] rd_mux;
  reg rd_hit;

  assign elided_abort_event = txn_abort & ~txn_kind_restricted;
  assign restricted_abort_event = txn_abort & txn_kind_restricted;
  assign setup = psel & ~penable;
  assign acc = psel & penable;
  // write lands only at the edge where the master sees pready high
  assign wr_take = acc & pready & pwrite;

  // per-counter select storage, event decode and counter instance
  genvar gi;
  generate
    for (gi = 0; gi < `TPF_NUM_CNT; gi = gi + 1) begin : g_cnt
      wire sel_en;
      wire prec_en;
      wire in_tx_eff;
      wire txn_checkpoint_filter_eff;
      wire cnt_wr;
      assign sel_en = sel_lo_ff[gi][`TPF_SEL_ENABLE_BIT];
      assign prec_en = sel_lo_ff[gi][`TPF_SEL_PRECISE_BIT];
      assign in_tx_eff = sel_hi_ff[gi][`TPF_SEL_INTX_BIT] & TXN_SUPPORTED;
      // checkpoint bit only wired where software may set it
      assign txn_checkpoint_filter_eff = (gi == `TPF_CKPT_CNT_IDX) ? (sel_hi_ff[gi][`TPF_SEL_INTXCP_BIT] & TXN_SUPPORTED) :
        1'b0;
      assign gen_hit[gi] = sel_en & core_evt_vld & evt_match(sel_lo_ff[gi], core_evt_code, core_evt_umask);
      assign abt_hit[gi] = sel_en &
        ((elided_abort_event & evt_match(sel_lo_ff[gi], `TPF_EVT_ELIDED_ABORT, `TPF_UMASK_ABORT)) |
         (restricted_abort_event & evt_match(sel_lo_ff[gi], `TPF_EVT_RESTR_ABORT, `TPF_UMASK_ABORT)));
      assign prec_gen[gi] = gen_hit[gi] & prec_en;
      assign prec_abt[gi] = abt_hit[gi] & prec_en;
      assign cnt_wr = wr_take && (paddr == `TPF_OFF_CNT0 + gi * `TPF_CNT_STRIDE);

      // select words written over the bus; upper select bits beyond 33 are not kept
      always @(posedge mclk) begin
        if (srst) begin
          sel_lo_ff[gi] <= `TPF_RST_WORD;
          sel_hi_ff[gi] <= 2'h0;
        end else if (wr_take && paddr == `TPF_OFF_EVTSEL_LO0 + gi * `TPF_EVTSEL_STRIDE) begin
          sel_lo_ff[gi] <= pwdata;
        end else if (wr_take && paddr == `TPF_OFF_EVTSEL_HI0 + gi * `TPF_EVTSEL_STRIDE) begin
          sel_hi_ff[gi] <= pwdata[1:0];
        end
      end

      tpf_cnt u_cnt (
        .mclk(mclk),
        .srst(srst),
        .evt_hit(gen_hit[gi] | abt_hit[gi]),
        .in_tx(in_tx_eff),
        .txn_checkpoint_filter(txn_checkpoint_filter_eff),
        .txn_active(txn_active),
        .txn_begin(txn_begin),
        .txn_abort(txn_abort),
        .wr_en(cnt_wr),
        .wr_data(pwdata),
        .cnt(cnt_val[gi])
      );
    end
  endgenerate

  // region cycle count; begin and closing cycles are both included
  assign cyc_now = txn_cyc_ff + 32'h00000001;
  assign abort_info_now = build_info(cyc_now, txn_kind_restricted, abort_instr, abort_retry,
    abort_conflict, abort_cap_wr, abort_cap_rd);
  // resume point depends on which mode aborted
  assign abort_resume_now = txn_kind_restricted ? fallback_ip : elided_restart_ip;

  always @(posedge mclk) begin
    if (srst) begin
      txn_cyc_ff <= `TPF_RST_WORD;
      last_cyc_ff <= `TPF_RST_WORD;
    end else begin
      if (txn_begin) begin
        txn_cyc_ff <= 32'h00000001; // begin cycle is the first region cycle
      end else if (txn_active) begin
        txn_cyc_ff <= cyc_now;
      end
      if (txn_commit | txn_abort) begin
        last_cyc_ff <= cyc_now;
      end
    end
  end

  // resume redirect towards the core on every abort
  always @(posedge mclk) begin
    if (srst) begin
      resume_valid <= 1'b0;
      resume_to_fallback <= 1'b0;
      resume_ip <= `TPF_RST_WORD;
    end else begin
      resume_valid <= txn_abort;
      if (txn_abort) begin
        resume_to_fallback <= txn_kind_restricted;
        resume_ip <= abort_resume_now;
      end
    end
  end

  // sampling order: abort before sample, sample two cycles after abort
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (|prec_abt) begin
          nxt_state = ST_EMIT;
        end else if ((|prec_gen) & txn_active) begin
          nxt_state = ST_WAIT;
        end else if (|prec_gen) begin
          nxt_state = ST_EMIT;
        end
      end
      ST_WAIT: begin
        if (txn_abort) begin
          nxt_state = ST_EMIT;
        end
      end
      ST_EMIT: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // record fields; abort-related records carry trigger ip, resume ip and abort info, with samp_partial set
  always @(posedge mclk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      txn_abort_req <= 1'b0;
      samp_valid <= 1'b0;
      samp_partial <= 1'b0;
      samp_trig_ip <= `TPF_RST_WORD;
      samp_resume_ip <= `TPF_RST_WORD;
      samp_abort_info <= `TPF_RST_INFO;
    end else begin
      state_ff <= nxt_state;
      samp_valid <= (state_ff == ST_EMIT);
      case (state_ff)
        ST_IDLE: begin
          if (|prec_abt) begin
            samp_trig_ip <= core_evt_ip;
            samp_resume_ip <= abort_resume_now;
            samp_abort_info <= abort_info_now;
            samp_partial <= 1'b1;
          end else if ((|prec_gen) & txn_active) begin
            txn_abort_req <= 1'b1;
            samp_trig_ip <= core_evt_ip;
          end else if (|prec_gen) begin
            samp_trig_ip <= core_evt_ip;
            samp_resume_ip <= core_evt_ip;
            samp_abort_info <= {32'h00000000, last_cyc_ff};
            samp_partial <= 1'b0;
          end
        end
        ST_WAIT: begin
          // request held until the core reports the abort
          if (txn_abort) begin
            txn_abort_req <= 1'b0;
            samp_resume_ip <= abort_resume_now;
            samp_abort_info <= abort_info_now;
            samp_partial <= 1'b1;
          end
        end
        default: begin
          txn_abort_req <= 1'b0;
        end
      endcase
    end
  end

  // sticky record-ready flag, write one to clear; a new record wins the tie
  always @(posedge mclk) begin
    if (srst) begin
      samp_pend_ff <= 1'b0;
    end else if (state_ff == ST_EMIT) begin
      samp_pend_ff <= 1'b1;
    end else if (wr_take && paddr == `TPF_OFF_SAMP_STAT && pwdata[0]) begin
      samp_pend_ff <= 1'b0;
    end
  end

  // read decode; unmapped addresses answer with an error
  integer ri;
  always @* begin
    rd_mux = `TPF_RST_WORD;
    rd_hit = 1'b0;
    for (ri = 0; ri < `TPF_NUM_CNT; ri = ri + 1) begin
      if (paddr == `TPF_OFF_EVTSEL_LO0 + ri * `TPF_EVTSEL_STRIDE) begin
        rd_mux = sel_lo_ff[ri];
        rd_hit = 1'b1;
      end
      if (paddr == `TPF_OFF_EVTSEL_HI0 + ri * `TPF_EVTSEL_STRIDE) begin
        rd_mux = {30'h00000000, sel_hi_ff[ri]};
        rd_hit = 1'b1;
      end
      if (paddr == `TPF_OFF_CNT0 + ri * `TPF_CNT_STRIDE) begin
        rd_mux = cnt_val[ri];
        rd_hit = 1'b1;
      end
    end
    case (paddr)
      `TPF_OFF_INFO_LO: begin
        rd_mux = samp_abort_info[31:0];
        rd_hit = 1'b1;
      end
      `TPF_OFF_INFO_HI: begin
        rd_mux = samp_abort_info[63:32];
        rd_hit = 1'b1;
      end
      `TPF_OFF_TRIG_IP: begin
        rd_mux = samp_trig_ip;
        rd_hit = 1'b1;
      end
      `TPF_OFF_RESUME_IP: begin
        rd_mux = samp_resume_ip;
        rd_hit = 1'b1;
      end
      `TPF_OFF_SAMP_STAT: begin
        rd_mux = {30'h00000000, samp_partial, samp_pend_ff};
        rd_hit = 1'b1;
      end
      default: begin
        rd_mux = rd_mux;
      end
    endcase
  end

  // one wait state: pready rises in the second access cycle, then drops
  always @(posedge mclk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `TPF_RST_WORD;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~rd_hit;
      if (acc & ~pready & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule // tpf_top
`default_nettype wire

// >>> dv/tpf_top_properties.sv
// assertion checker for the transaction-aware counter filter
`timescale 1ns/10ps
`default_nettype none
module tpf_top_chk (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic txn_abort,
  input wire logic txn_kind_restricted,
  input wire logic [31:0] elided_restart_ip,
  input wire logic [31:0] fallback_ip,
  input wire logic txn_abort_req,
  input wire logic samp_valid,
  input wire logic samp_partial,
  input wire logic [63:0] samp_abort_info,
  input wire logic resume_valid,
  input wire logic resume_to_fallback,
  input wire logic [31:0] resume_ip
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // upper record bits stay clear
  rsvd_zero_a: assert property (samp_valid |-> samp_abort_info[63:40] == 24'h0)
    else $error("abort info reserved bits set");
  instr_pair_a: assert property (samp_valid && samp_partial |-> samp_abort_info[35] != samp_abort_info[34])
    else $error("instr and non-instr bits agree");
  abort_kind_a: assert property (samp_valid && samp_partial |-> ^samp_abort_info[33:32])
    else $error("abort kind bits not one-hot");
  resume_pulse_a: assert property (txn_abort |=> resume_valid)
    else $error("no resume pulse after abort");
  fallback_ip_a: assert property (txn_abort && txn_kind_restricted |=> resume_to_fallback && resume_ip == $past(fallback_ip))
    else $error("restricted abort resume wrong");
  restart_ip_a: assert property (txn_abort && !txn_kind_restricted |=> !resume_to_fallback && resume_ip == $past(elided_restart_ip))
    else $error("elided abort resume wrong");
  // request must hold until the core has aborted
  req_hold_a: assert property (txn_abort_req && !txn_abort |=> txn_abort_req)
    else $error("abort request dropped early");
  abort_first_a: assert property (txn_abort_req && txn_abort |=> !txn_abort_req ##1 (samp_valid && samp_partial))
    else $error("sample not two cycles after forced abort");
  sample_after_a: assert property (samp_valid && samp_partial |-> $past(txn_abort, 2))
    else $error("abort record without prior abort");
  // one wait state on every access
  apb_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("apb answer timing wrong");
endmodule // tpf_top_chk

bind tpf_top tpf_top_chk u_chk (.mclk, .srst, .psel, .penable, .pready, .txn_abort, .txn_kind_restricted,
  .elided_restart_ip, .fallback_ip, .txn_abort_req, .samp_valid, .samp_partial, .samp_abort_info,
  .resume_valid, .resume_to_fallback, .resume_ip);
`default_nettype wire

// >>> dv/tpf_core.sv
// core-side model: transactional regions, events and abort details
`timescale 1ns/10ps
`default_nettype none
module tpf_core (
  input wire logic mclk,
  input wire logic txn_abort_req,
  output logic core_evt_vld,
  output logic [7:0] core_evt_code,
  output logic [7:0] core_evt_umask,
  output logic [31:0] core_evt_ip,
  output logic txn_active,
  output logic txn_begin,
  output logic txn_commit,
  output logic txn_abort,
  output logic txn_kind_restricted,
  output logic [4:0] abort_why,
  output logic [31:0] elided_restart_ip,
  output logic [31:0] fallback_ip
);
  logic [31:0] ip_ff = 32'h1000;
  initial begin
    {core_evt_vld, core_evt_code, core_evt_umask, core_evt_ip} = {1'b0, 8'h5A, 8'hA5, 32'h0};
    {txn_active, txn_begin, txn_commit, txn_abort, txn_kind_restricted, abort_why} = 10'h0;
    {elided_restart_ip, fallback_ip} = 64'h0;
  end
  // idle event lines flip each cycle so stale values never pass as real
  task automatic ev(input logic v, input logic [7:0] c, input logic [7:0] u);
    core_evt_vld <= v;
    core_evt_code <= v ? c : ~core_evt_code;
    core_evt_umask <= v ? u : ~core_evt_umask;
    core_evt_ip <= v ? ip_ff : ~core_evt_ip;
    ip_ff = ip_ff + 32'h4;
  endtask
  task automatic idle(input int n, input logic [7:0] c);
    repeat (n) begin
      @(posedge mclk);
      ev(1'b1, c, 8'h00);
    end
    @(posedge mclk);
    ev(1'b0, c, 8'h00);
  endtask
  // region cut short once the block asks for an abort
  task automatic region(input int n, input logic [7:0] c, input logic ab, input logic k,
                        input logic [4:0] why, input logic [31:0] rip, output int len, output logic [31:0] fip);
    int i;
    @(posedge mclk);
    txn_active <= 1'b1;
    txn_begin <= 1'b1;
    ev(1'b0, c, 8'h00);
    fip = ip_ff;
    for (i = 0; i < n && !txn_abort_req; i++) begin
      @(posedge mclk);
      txn_begin <= 1'b0;
      ev(1'b1, c, 8'h00);
    end
    @(posedge mclk);
    ab = ab | txn_abort_req;
    txn_begin <= 1'b0;
    txn_commit <= !ab;
    txn_abort <= ab;
    txn_kind_restricted <= k;
    abort_why <= why;
    elided_restart_ip <= rip;
    fallback_ip <= ~rip;
    ev(ab, k ? 8'hC9 : 8'hC8, 8'h04);
    len = i + 2;
    @(posedge mclk);
    txn_active <= 1'b0;
    txn_commit <= 1'b0;
    txn_abort <= 1'b0;
    ev(1'b0, c, 8'h00);
  endtask
endmodule // tpf_core
`default_nettype wire

// >>> dv/tb_txn_aware_perf_counter_filter.sv
// self-checking bench: counter filters, precise samples, abort record
`timescale 1ns/10ps
`default_nettype none
module tb_txn_aware_perf_counter_filter;
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, e, ab;
  logic [7:0] paddr, core_evt_code, core_evt_umask;
  logic [31:0] pwdata, prdata, core_evt_ip, elided_restart_ip, fallback_ip, samp_trig_ip, samp_resume_ip;
  logic [31:0] resume_ip, q, v, fip, seed = 32'hB8586435;
  logic core_evt_vld, txn_active, txn_begin, txn_commit, txn_abort, txn_kind_restricted, txn_abort_req;
  logic samp_valid, samp_partial, resume_valid, resume_to_fallback;
  logic [4:0] abort_why;
  logic [63:0] samp_abort_info;
  logic [31:0] m [4] = '{default: 32'h0};
  int fail_count = 0, total_checks = 0, i, k, r, n, len;

  tpf_top u_dut (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .core_evt_vld, .core_evt_code, .core_evt_umask, .core_evt_ip, .txn_active, .txn_begin, .txn_commit,
    .txn_abort, .txn_kind_restricted, .abort_instr(abort_why[0]), .abort_retry(abort_why[1]),
    .abort_conflict(abort_why[2]), .abort_cap_wr(abort_why[3]), .abort_cap_rd(abort_why[4]),
    .elided_restart_ip, .fallback_ip, .txn_abort_req, .samp_valid, .samp_partial, .samp_trig_ip,
    .samp_resume_ip, .samp_abort_info, .resume_valid, .resume_to_fallback, .resume_ip);
  tpf_core u_core (.mclk, .txn_abort_req, .core_evt_vld, .core_evt_code, .core_evt_umask, .core_evt_ip,
    .txn_active, .txn_begin, .txn_commit, .txn_abort, .txn_kind_restricted, .abort_why,
    .elided_restart_ip, .fallback_ip);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic give_verdict();
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang();
    fail_count++;
    give_verdict();
  endtask
  // wide enough for a flag beside the full 64-bit record
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (t = 0; t < 20; t++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (t == 20) hang();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk({e, q}, {1'b0, x});
  endtask
  task automatic waitv();
    int t;
    for (t = 0; t < 40 && samp_valid !== 1'b1; t++) @(posedge mclk);
    if (t == 40) hang();
  endtask

  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    for (i = 0; i < 4; i++) rd(8'(8'h20 + 4 * i), 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    // sel0 inside-only, sel1 plain, sel2 checkpoint, sel3 other code
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h14, 32'h2);
    for (i = 0; i < 3; i++) apb(1'b1, 8'(8 * i), 32'h00400011);
    apb(1'b1, 8'h18, 32'h00400022);
    m[2] = 32'hFFFFFFF8;
    apb(1'b1, 8'h28, m[2]);
    for (r = 0; r < 6; r++) begin
      n = rnd() % 4;
      u_core.idle(n, 8'h11);
      m[1] += n;
      m[2] += n;
      v = rnd();
      ab = v[0];
      n = 1 + v[3:1];
      u_core.region(n, 8'h11, ab, v[4], v[9:5], v, len, fip);
      m[0] += n;
      m[1] += n;
      if (!ab) m[2] += n;
      for (i = 0; i < 4; i++) rd(8'(8'h20 + 4 * i), m[i]);
    end
    // precise event inside a region forces an abort first
    apb(1'b1, 8'h18, 32'h00420033);
    u_core.region(6, 8'h33, 1'b0, 1'b1, 5'h1, 32'h0, len, fip);
    waitv();
    chk({samp_partial, samp_trig_ip, samp_abort_info[33:32]}, {1'b1, fip, 2'b10});
    // committed region then a precise event outside
    u_core.region(3, 8'h11, 1'b0, 1'b0, 5'h0, 32'h0, len, fip);
    u_core.idle(1, 8'h33);
    waitv();
    chk({samp_partial, samp_abort_info}, {1'b0, 32'h0, 32'(len)});
    // both abort events as precise sources, random abort causes
    for (k = 0; k < 4; k++) begin
      apb(1'b1, 8'h18, k[0] ? 32'h004204C9 : 32'h004204C8);
      v = rnd();
      u_core.region(2, 8'h11, 1'b1, k[0], v[4:0], v, len, fip);
      waitv();
      chk(samp_abort_info, {24'h0, v[4:1], ~v[0], v[0], k[0], ~k[0], 32'(len)});
      chk({resume_to_fallback, samp_resume_ip}, {k[0], k[0] ? ~v : v});
    end
    give_verdict();
  end
endmodule // tb_txn_aware_perf_counter_filter
`default_nettype wire
